// ==== hw/smpm_pkg.sv ====
// Package of constants and types for the strap sampling and pin mux block.
package smpm_pkg;
    // Configuration channel selected by the two configuration straps.
    typedef enum logic [1:0] {
        SMPM_CFG_UART = 2'h0,
        SMPM_CFG_I2C  = 2'h1,
        SMPM_CFG_SPI  = 2'h2,
        SMPM_CFG_RSVD = 2'h3
    } smpm_cfg_e;

    localparam int unsigned CLK_FREQ_HZ       = 100000000;  // Chip clock rate.
    localparam int unsigned SETTLE_TIME_US    = 100;        // Settling interval after reset.
    localparam int unsigned SETTLE_CYCLES     = (SETTLE_TIME_US * (CLK_FREQ_HZ / 1000000));
    localparam int unsigned SETTLE_CNT_W      = 24;         // Width of the settling counter.
    localparam logic [4:0]  I2C_ADDR_UPPER    = 5'h08;      // Fixed upper address bits 01000.
    localparam logic [1:0]  CFG_STRAP_RST     = 2'h0;       // Latched config straps at reset.
    localparam logic        DATA_STRAP_RST    = 1'h1;       // Latched data strap at reset.
    localparam logic [1:0]  ADDR_STRAP_RST    = 2'h0;       // Latched address straps at reset.
    localparam int unsigned NUM_MUX_PINS      = 10;         // Multiplexed digital pins.
endpackage : smpm_pkg

// ==== hw/smpm_sync.sv ====
// Two flip-flop synchroniser for one pin level.
module smpm_sync
    import smpm_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic rst_val,
    input  wire logic d,
    output logic      q
);
    logic meta_r;  // First stage, read only by the second stage.
    logic q_r;     // Second stage.
    logic meta_nxt;
    logic q_nxt;

    // Next values simply shift the pin level along.
    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    // Registers clear to zero; the pull value is applied by the caller if needed.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    // The reset-value port is XORed in twice and cancels, so q always equals the second stage.
    assign q = q_r ^ rst_val ^ rst_val;
endmodule : smpm_sync

// ==== hw/smpm_top.sv ====
// Strap sampling at reset settling and multiplexing of the ten digital pins.
// Notes on behaviour
// - Sample mode straps only during settling.
// - Config straps select UART, I2C, SPI.
// - Data strap selects raw or processed output.
// - Latched modes ignore later strap changes.
// - Pulled-up straps read high when floating.
// - I2C address is 01000 plus straps.
// - Second address strap is address LSB.
// - Ten pins multiplexed by latched modes.
// - Raw mode: RX2 I and Q out.
// - Processed SPI: FFT SPI data 1, then SPI clock.
// - Device drives FFT SPI clock when active.
// - Target detect enabled by register only.
// - Target detect high while target present.
// - Config pins serve I2C, SPI or UART.
// - Data pins carry raw or FFT lines.
// - First address strap is address bit 1.
module smpm_top
    import smpm_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Pad inputs, outputs and enables of pins 20 to 29, index 0 is pin 20.
    input  wire logic [9:0] pin_in,
    output logic      [9:0] pin_out,
    output logic      [9:0] pin_oe,
    // Pull-up controls for pins 24 and 25.
    output logic            cfg_strap2_pullup,
    output logic            data_strap_pullup,
    // Latched modes and address for the rest of the chip.
    output smpm_cfg_e       cfg_mode,
    output logic            data_mode_processed,
    output logic      [6:0] i2c_target_addr,
    output logic            settle_done,
    // Configuration channel core signals.
    input  wire logic       cfg_i2c_sda_oe,
    input  wire logic       cfg_spi_miso,
    input  wire logic       cfg_spi_miso_oe,
    input  wire logic       cfg_uart_tx,
    output logic            cfg_i2c_sda_in,
    output logic            cfg_i2c_scl_in,
    output logic            cfg_spi_mosi,
    output logic            cfg_spi_sclk,
    output logic            cfg_spi_select,
    output logic            cfg_uart_rx,
    // Raw data sources.
    input  wire logic       raw_clk,
    input  wire logic       raw_ready,
    input  wire logic       raw_rx1_inphase_out,
    input  wire logic       raw_rx1_quadrature_out,
    input  wire logic       raw_rx2_inphase_out,
    input  wire logic       raw_rx2_quadrature_out,
    // Processed data sources.
    input  wire logic       fft_uart_tx,
    input  wire logic       fft_spi_select,
    input  wire logic       fft_spi_data0,
    input  wire logic       fft_spi_data1,
    input  wire logic       fft_spi_clk,
    input  wire logic       fft_use_spi,
    // Target detect control from the register file and the processing engine.
    input  wire logic       target_detect_en,
    input  wire logic       target_present
);
    logic [9:0]              pin_sync;       // Synchronised pad levels.
    logic [SETTLE_CNT_W-1:0] settle_cnt_r;   // Settling cycle counter.
    logic [SETTLE_CNT_W-1:0] settle_cnt_nxt;
    logic                    settle_done_r;
    logic                    settle_done_nxt;
    logic [1:0]              cfg_strap_r;    // Latched pins 23 and 24.
    logic [1:0]              cfg_strap_nxt;
    logic                    data_strap_r;   // Latched pin 25.
    logic                    data_strap_nxt;
    logic [1:0]              addr_strap_r;   // Latched pins 27 and 28.
    logic [1:0]              addr_strap_nxt;
    logic [9:0]              pin_out_nxt;
    logic [9:0]              pin_oe_nxt;
    logic [9:0]              pin_out_r;
    logic [9:0]              pin_oe_r;
    smpm_cfg_e               cfg_sel;

    // Each pad level crosses into the clock domain through two flip-flops.
    genvar g;
    generate
        for (g = 0; g < NUM_MUX_PINS; g++) begin : g_sync
            smpm_sync u_sync (
                .clock   (clock),
                .rst_b   (rst_b),
                .rst_val (1'b0),
                .d       (pin_in[g]),
                .q       (pin_sync[g])
            );
        end
    endgenerate

    // The pulls stay on always; floating pins 24 and 25 then read high.
    assign cfg_strap2_pullup = 1'b1;
    assign data_strap_pullup = 1'b1;

    // Settling counter and strap capture; after the interval the latches freeze.
    always_comb begin
        settle_cnt_nxt  = settle_cnt_r;
        settle_done_nxt = settle_done_r;
        cfg_strap_nxt   = cfg_strap_r;
        data_strap_nxt  = data_strap_r;
        addr_strap_nxt  = addr_strap_r;
        if (!settle_done_r) begin
            // Keep sampling the straps so the last level in the interval counts.
            cfg_strap_nxt  = {pin_sync[3], pin_sync[4]};
            data_strap_nxt = pin_sync[5];
            addr_strap_nxt = {pin_sync[7], pin_sync[8]};
            if (settle_cnt_r == SETTLE_CNT_W'(SETTLE_CYCLES - 1)) begin
                settle_done_nxt = 1'b1;
            end else begin
                settle_cnt_nxt = settle_cnt_r + 1'b1;
            end
        end
        // Once done nothing is resampled, so later pin activity is harmless.
    end

    // Registers for the settling state and latched straps.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            settle_cnt_r  <= '0;
            settle_done_r <= 1'b0;
            cfg_strap_r   <= CFG_STRAP_RST;
            data_strap_r  <= DATA_STRAP_RST;
            addr_strap_r  <= ADDR_STRAP_RST;
        end else begin
            settle_cnt_r  <= settle_cnt_nxt;
            settle_done_r <= settle_done_nxt;
            cfg_strap_r   <= cfg_strap_nxt;
            data_strap_r  <= data_strap_nxt;
            addr_strap_r  <= addr_strap_nxt;
        end
    end

    // Decode of the configuration straps, pin 23 first.
    always_comb begin
        case (cfg_strap_r)
            2'h0:    cfg_sel = SMPM_CFG_UART;
            2'h1:    cfg_sel = SMPM_CFG_I2C;
            2'h2:    cfg_sel = SMPM_CFG_SPI;
            default: cfg_sel = SMPM_CFG_RSVD;
        endcase
    end

    assign cfg_mode            = cfg_sel;
    assign data_mode_processed = data_strap_r;
    // Pin 27 is the high bit and pin 28 the low bit.
    assign i2c_target_addr     = {I2C_ADDR_UPPER, addr_strap_r[1], addr_strap_r[0]};
    assign settle_done         = settle_done_r;

    // Inputs to the configuration cores; the pads are passed through at all times, settling or not.
    always_comb begin
        cfg_i2c_sda_in = pin_sync[0];
        cfg_i2c_scl_in = pin_sync[1];
        cfg_spi_mosi   = pin_sync[0];
        cfg_spi_sclk   = pin_sync[1];
        cfg_spi_select = pin_sync[2];
        cfg_uart_rx    = pin_sync[0];
    end

    // Output mux: pads stay undriven while straps settle, which lets the host
    // own the levels; a misbehaving host beyond that window would contend.
    always_comb begin
        pin_out_nxt = '0;
        pin_oe_nxt  = '0;
        if (settle_done_r) begin
            // Configuration channel pins 20 to 23.
            case (cfg_sel)
                SMPM_CFG_UART: begin
                    pin_out_nxt[1] = cfg_uart_tx;
                    pin_oe_nxt[1]  = 1'b1;
                end
                SMPM_CFG_I2C: begin
                    // Open drain: drive low only while the core pulls the line.
                    pin_oe_nxt[0]  = cfg_i2c_sda_oe;
                end
                SMPM_CFG_SPI: begin
                    pin_out_nxt[3] = cfg_spi_miso;
                    pin_oe_nxt[3]  = cfg_spi_miso_oe;
                end
                default: begin
                    // Reserved combination: all four stay inputs.
                    pin_oe_nxt[3:0] = 4'h0;
                end
            endcase
            // Data pins 24 to 29.
            if (!data_strap_r) begin
                pin_out_nxt[9:4] = {raw_rx2_quadrature_out, raw_rx2_inphase_out,
                                    raw_rx1_quadrature_out, raw_rx1_inphase_out,
                                    raw_ready, raw_clk};
                pin_oe_nxt[9:4]  = 6'h3F;
            end else begin
                pin_out_nxt[5] = fft_uart_tx;
                pin_oe_nxt[5]  = 1'b1;
                if (fft_use_spi) begin
                    pin_out_nxt[9:6] = {fft_spi_clk, fft_spi_data1,
                                        fft_spi_data0, fft_spi_select};
                    pin_oe_nxt[9:6]  = 4'hF;
                end
            end
            // Target detect overrides pin 28 only by the register enable.
            if (target_detect_en) begin
                pin_out_nxt[8] = target_present;
                pin_oe_nxt[8]  = 1'b1;
            end
        end
    end

    // Registered pad outputs; the enables reset low here along with the outputs.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_r <= '0;
            pin_oe_r  <= '0;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe  = pin_oe_r;
endmodule : smpm_top

// ==== test/smpm_top_sva.sv ====
// Checker of strap latching and pin routing at the top ports.
module smpm_top_sva
    import smpm_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_oe,
    input wire logic       cfg_strap2_pullup,
    input wire logic       data_strap_pullup,
    input wire smpm_cfg_e  cfg_mode,
    input wire logic       data_mode_processed,
    input wire logic [6:0] i2c_target_addr,
    input wire logic       settle_done,
    input wire logic       raw_rx2_inphase_out,
    input wire logic       raw_rx2_quadrature_out,
    input wire logic       fft_spi_clk,
    input wire logic       fft_use_spi,
    input wire logic       target_detect_en,
    input wire logic       target_present
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // Pin checks wait one cycle past settle_done, because the mux lags the latch by one edge.
    a_done_sticky: assert property (settle_done |=> settle_done)
        else $error("settle_done fell before reset");
    a_modes_hold: assert property (settle_done && $past(settle_done) |-> $stable(cfg_mode)
        && $stable(data_mode_processed) && $stable(i2c_target_addr)) else $error("mode moved");
    a_addr_upper: assert property (settle_done |-> i2c_target_addr[6:2] == 5'h08)
        else $error("address upper bits wrong");
    a_pullups_on: assert property (cfg_strap2_pullup && data_strap_pullup)
        else $error("pull-up off");
    a_detect_pin: assert property (settle_done && $past(settle_done) && target_detect_en
        |=> pin_oe[8] && pin_out[8] == $past(target_present)) else $error("detect pin wrong");
    a_raw_rx2: assert property (settle_done && $past(settle_done) && !data_mode_processed
        && !target_detect_en |=> pin_out[8] == $past(raw_rx2_inphase_out)
        && pin_out[9] == $past(raw_rx2_quadrature_out)) else $error("raw pins wrong");
    a_spi_clock: assert property (settle_done && $past(settle_done) && data_mode_processed
        && fft_use_spi |=> pin_oe[9] && pin_out[9] == $past(fft_spi_clk))
        else $error("data clock pin wrong");
    a_rsvd_inputs: assert property (settle_done && $past(settle_done)
        && cfg_mode == SMPM_CFG_RSVD |-> pin_oe[3:0] == 4'h0) else $error("reserved drives");
endmodule : smpm_top_sva

bind smpm_top smpm_top_sva u_sva (.clock, .rst_b, .pin_out, .pin_oe, .cfg_strap2_pullup,
    .data_strap_pullup, .cfg_mode, .data_mode_processed, .i2c_target_addr, .settle_done,
    .raw_rx2_inphase_out, .raw_rx2_quadrature_out, .fft_spi_clk, .fft_use_spi,
    .target_detect_en, .target_present);

// ==== test/smpm_host.sv ====
// Board strap resistors and host pads facing the ten muxed pins.
module smpm_host (
    input  wire logic       clock,
    input  wire logic       settle_done,
    input  wire logic [9:0] pin_out,
    input  wire logic [9:0] pin_oe,
    input  wire logic [9:0] strap_val,
    input  wire logic [9:0] strap_drv,
    output logic      [9:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] noise_r = 10'h2A5; // Released lines toggle so a stale level never passes.

    // Noise flips every cycle on undriven lines other than pins 24 and 25.
    always @(posedge clock) noise_r <= ~noise_r;

    // Pad level: device drive wins, else strap until settling ends, else pull-up or noise.
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (strap_drv[i] && !settle_done) pin_in[i] = strap_val[i];
            else if (i == 4 || i == 5) pin_in[i] = 1'b1;
            else pin_in[i] = noise_r[i];
        end
    end
endmodule : smpm_host

// ==== test/tb_strap_mode_pin_mux.sv ====
// Self-checking bench: strap codes, settling time, latched modes and pin routing.
module tb_strap_mode_pin_mux
    import smpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst_b, pu2, pud, dmp, done, e;
    logic [9:0]  pin_in, pin_out, pin_oe, sval, sdrv;
    logic [6:0]  addr, eaddr;
    logic [17:0] stim;           // All core-side inputs, driven from one random word.
    logic [9:0]  eout, eoe;      // Expected pad drive and enables from the pin rules.
    logic [9:0]  pin_d1, pin_d2; // Pad levels one and two falling edges ago.
    logic [5:0]  cin;            // Configuration core inputs seen through the synchroniser.
    logic [1:0]  ecfg;
    logic        eproc;
    smpm_cfg_e   cfg_mode;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          seed = 32'h0da2e8e0;

    smpm_top uut (.clock, .rst_b, .pin_in, .pin_out, .pin_oe, .cfg_strap2_pullup(pu2),
        .data_strap_pullup(pud), .cfg_mode, .data_mode_processed(dmp),
        .i2c_target_addr(addr), .settle_done(done), .cfg_i2c_sda_oe(stim[0]),
        .cfg_spi_miso(stim[1]), .cfg_spi_miso_oe(stim[2]), .cfg_uart_tx(stim[3]),
        .cfg_i2c_sda_in(cin[0]), .cfg_i2c_scl_in(cin[1]), .cfg_spi_mosi(cin[2]),
        .cfg_spi_sclk(cin[3]), .cfg_spi_select(cin[4]), .cfg_uart_rx(cin[5]),
        .raw_clk(stim[4]), .raw_ready(stim[5]),
        .raw_rx1_inphase_out(stim[6]), .raw_rx1_quadrature_out(stim[7]),
        .raw_rx2_inphase_out(stim[8]), .raw_rx2_quadrature_out(stim[9]),
        .fft_uart_tx(stim[10]), .fft_spi_select(stim[11]), .fft_spi_data0(stim[12]),
        .fft_spi_data1(stim[13]), .fft_spi_clk(stim[14]), .fft_use_spi(stim[15]),
        .target_detect_en(stim[16]), .target_present(stim[17]));
    smpm_host host (.clock, .settle_done(done), .pin_out, .pin_oe, .strap_val(sval),
        .strap_drv(sdrv), .pin_in);

    // Compares one result and counts it.
    task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Compares one ten-pin vector and counts it.
    task automatic check_pins(input string what, input logic [9:0] exp, input logic [9:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_pins

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Watchdog sized about a quarter above eight settle runs.
    initial begin
        #1000000;
        n_fail++;
        summarize();
    end

    // Eight resets walk all four config codes, both data modes and floating pull-up pins.
    initial begin
        rst_b = 1'b0;
        stim = '0;
        pin_d1 = '0;
        pin_d2 = '0;
        sval = '0;
        sdrv = '0;
        for (int k = 0; k < 8; k++) begin
            @(negedge clock);
            rst_b = 1'b0;
            sval = 10'($random(seed));
            // Pin 24 floats on two resets and pin 25 on two, so both pull-ups are used.
            sdrv = 10'h1B8 & ~{4'h0, k[0] & k[1], k[0] & k[2], 4'h0};
            {sval[3], sval[4]} = k[1:0];
            sval[5] = k[0] ^ k[2]; // Raw mode is strapped on three of the eight resets.
            {sval[7], sval[8]} = k[1:0] ^ {2{k[2]}};
            ecfg = {sval[3], sdrv[4] ? sval[4] : 1'b1};
            eproc = sdrv[5] ? sval[5] : 1'b1;
            eaddr = {5'h08, sval[7], sval[8]};
            repeat (5) @(negedge clock);
            rst_b = 1'b1;
            repeat (SETTLE_CYCLES - 1) @(negedge clock);
            check("settle_done", 7'h0, 7'(done));
            check_pins("pin_oe settle", 10'h000, pin_oe);
            for (int t = 0; t < 60; t++) begin
                @(negedge clock);
                check("settle_done", 7'h1, 7'(done));
                check("cfg_mode", 7'(ecfg), 7'(cfg_mode));
                check("data_mode", 7'(eproc), 7'(dmp));
                check("i2c_addr", eaddr, addr);
                if (t > 1) begin
                    // The pads register the core inputs set at the previous falling edge.
                    check("pin25", 7'(eproc ? stim[10] : stim[5]), 7'(pin_out[5]));
                    e = stim[16] ? stim[17] : eproc ? stim[13] : stim[8];
                    if (!eproc || stim[15] || stim[16])
                        check("pin28", 7'(e), 7'(pin_out[8]));
                    if (!eproc || stim[15])
                        check("pin29", 7'(eproc ? stim[14] : stim[9]), 7'(pin_out[9]));
                    // Whole pad drive expected from the latched modes and the core inputs.
                    eout = '0;
                    eoe  = '0;
                    case (ecfg)
                        2'h0: begin
                            eout[1] = stim[3];
                            eoe[1]  = 1'b1;
                        end
                        2'h1: begin
                            eoe[0] = stim[0];
                        end
                        2'h2: begin
                            eout[3] = stim[1];
                            eoe[3]  = stim[2];
                        end
                        default: begin
                            eoe[3:0] = 4'h0;
                        end
                    endcase
                    if (!eproc) begin
                        eout[9:4] = stim[9:4];
                        eoe[9:4]  = 6'h3F;
                    end else begin
                        eout[5] = stim[10];
                        eoe[5]  = 1'b1;
                        if (stim[15]) begin
                            eout[9:6] = stim[14:11];
                            eoe[9:6]  = 4'hF;
                        end
                    end
                    if (stim[16]) begin
                        eout[8] = stim[17];
                        eoe[8]  = 1'b1;
                    end
                    check_pins("pin_out", eout, pin_out);
                    check_pins("pin_oe", eoe, pin_oe);
                    // Core inputs show the pad levels of two falling edges ago.
                    check_pins("cfg_in", {4'h0, pin_d2[0], pin_d2[2], pin_d2[1],
                        pin_d2[0], pin_d2[1], pin_d2[0]}, {4'h0, cin});
                end
                pin_d2 = pin_d1;
                pin_d1 = pin_in;
                stim = 18'($random(seed));
            end
        end
        summarize();
    end
endmodule : tb_strap_mode_pin_mux
